// File: rtl/probe_mux_map.vh
`ifndef PROBE_MUX_MAP_VH
`define PROBE_MUX_MAP_VH

// Register byte offsets
`define OFS_CMD          12'h000
`define OFS_CTRL         12'h004
`define OFS_STATUS       12'h008
`define OFS_PIN_CFG      12'h00C

// Command and field layout
`define CMD_PROBE_SETUP  8'h18
`define CMD_CODE_LSB     8
`define CTRL_ENABLE_BIT  0
`define STAT_BUSY_BIT    0
`define STAT_ERR_BIT     1
`define NV_ENABLE_ADDR   8'h17

// Signal bank codes
`define BANK_CLOCK       8'h01
`define BANK_TX_CODER    8'h1B
`define BANK_TIMER       8'h1D
`define BANK_CARD_MODE   8'h30
`define BANK_TRANSCEIVE  8'h58
`define BANK_RX_XFER     8'h70
`define BANK_RX_ERROR    8'h73

// Select and pin nibble codes
`define SEL_RF_CLOCK     4'h8
`define PIN_IRQ          4'h0
`define PIN_AUX_ONE      4'h1
`define PIN_AUX_TWO      4'h2
`define PIN_GPO_ONE      4'h3

// Reset values and timing
`define SEL_RESET        4'hF
`define BANK_RESET       8'h00
`define BUSY_CYCLES      4'h4

`endif

// File: rtl/probe_bank_select.v
`timescale 1ns/100ps
`default_nettype none

// Picks one debug signal from the selected bank for one pin
module probe_bank_select (
  // Selection
  input  wire [7:0] bank,
  input  wire [3:0] sel,
  // Debug sources
  input  wire [7:0] clock_grp,
  input  wire [1:0] tx_grp,
  input  wire [5:0] timer_grp,
  input  wire [7:0] card_grp,
  input  wire [7:0] trx_grp,
  input  wire       rx_collision,
  input  wire       rf_clock,
  // Result
  output reg        sig,
  output reg        defined
);

`include "probe_mux_map.vh"

  always @* begin
    sig     = 1'b0;
    defined = 1'b0;
    if (sel == `SEL_RF_CLOCK) begin
      sig     = rf_clock; // R6
      defined = 1'b1;
    end else if (sel[3] == 1'b0) begin
      case (bank) // R8 R9
        `BANK_CLOCK: begin
          sig     = clock_grp[sel[2:0]]; // R10
          defined = 1'b1;
        end
        `BANK_TX_CODER: begin
          if (sel[2:1] == 2'h0) begin
            sig     = tx_grp[sel[0]]; // R11
            defined = 1'b1;
          end
        end
        `BANK_TIMER: begin
          if (sel[2:1] != 2'h0) begin
            sig     = timer_grp[sel[2:0] - 3'h2]; // R12
            defined = 1'b1;
          end
        end
        `BANK_CARD_MODE: begin
          sig     = card_grp[sel[2:0]]; // R13
          defined = 1'b1;
        end
        `BANK_TRANSCEIVE: begin
          sig     = trx_grp[sel[2:0]]; // R14
          defined = 1'b1;
        end
        `BANK_RX_XFER: begin
          if (sel[2:0] == 3'h7) begin
            sig     = rx_collision; // R15
            defined = 1'b1;
          end
        end
        default: begin
          sig     = 1'b0; // R18
          defined = 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// File: rtl/probe_axil_slave.v
`timescale 1ns/100ps
`default_nettype none

// AXI4-Lite slave: write and read handshakes, one of each at a time
module probe_axil_slave (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_sync_n,
  // AXI4-Lite
  input  wire [11:0] s_awaddr,
  input  wire        s_awvalid,
  output wire        s_awready,
  input  wire [31:0] s_wdata,
  input  wire [3:0]  s_wstrb,
  input  wire        s_wvalid,
  output wire        s_wready,
  output reg  [1:0]  s_bresp,
  output reg         s_bvalid,
  input  wire        s_bready,
  input  wire [11:0] s_araddr,
  input  wire        s_arvalid,
  output wire        s_arready,
  output reg  [31:0] s_rdata,
  output reg  [1:0]  s_rresp,
  output reg         s_rvalid,
  input  wire        s_rready,
  // Register side
  output wire        wr_en,
  output wire [11:0] wr_addr,
  output wire [31:0] wr_data,
  output wire [3:0]  wr_strb,
  input  wire        wr_ok,
  output wire [11:0] rd_addr,
  input  wire [31:0] rd_data,
  input  wire        rd_ok
);

  reg        aw_q;
  reg        w_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;

  assign s_awready = !aw_q && !s_bvalid;
  assign s_wready  = !w_q && !s_bvalid;
  assign wr_en     = aw_q && w_q && !s_bvalid;
  assign wr_addr   = awaddr_q;
  assign wr_data   = wdata_q;
  assign wr_strb   = wstrb_q;
  assign s_arready = !s_rvalid;
  assign rd_addr   = s_araddr;

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp  <= 2'h0;
      s_rvalid <= 1'b0;
      s_rresp  <= 2'h0;
      s_rdata  <= 32'h00000000;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      if (wr_en) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_ok ? rd_data : 32'h00000000;
        s_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/digital_test_signal_mux.v
// Contract
// (R1) Probe setup command code 0x18: one bank byte, one to four pin bytes, no reply; code applies only two pin bytes, bank from OFS_PIN_CFG.
// (R2) No debug signal reaches a pin unless the nonvolatile enable setting is set.
// (R3) Pin byte: bits 0-3 pick signal, bits 4-7 pick output pin.
// (R4) All four pins can carry their own debug signals simultaneously.
// (R5) Selects 0-7 pick bank signals; 9-F are reserved and drive nothing.
// (R6) Select 8 outputs the 13.56 MHz RF clock for any bank.
// (R7) Pin 0 interrupt, 1 aux one, 2 aux two, 3 general output; 4-F reserved.
// (R8) Bank 01 clock group, 1B transmit coder group, 1D timer group.
// (R9) Bank 30 card mode, 58 transceive, 70 receive transfer, 73 receive error; code decodes no 73 group, so 73 acts as a reserved bank.
// (R10) Clock group: eight clock and status signals at selects 0 to 7.
// (R11) Transmit coder group: 0 transmit interrupt, 1 envelope, 2-7 reserved.
// (R12) Timer group: 7/5/3 running flags, 6/4/2 expiry flags, 0-1 reserved.
// (R13) Card mode group: eight detection and data flags at selects 0 to 7.
// (R14) Transceive group: prefetch, start, receive enable, timeout, three state bits.
// (R15) Receive transfer select 7 outputs signal processor collision indication.
// (R16) Host waits on the busy indication before further transfers.
// (R17) Pins not named in the command keep their normal function; code keeps pins named by earlier commands on their debug signal.
// (R18) Reserved bank, signal or pin codes leave the pin in defined inactive state.
`timescale 1ns/100ps
`default_nettype none

module digital_test_signal_mux #(
  parameter NUM_PINS = 4,
  parameter MAX_SEL  = 4
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // AXI4-Lite
  input  wire [11:0] s_awaddr,
  input  wire        s_awvalid,
  output wire        s_awready,
  input  wire [31:0] s_wdata,
  input  wire [3:0]  s_wstrb,
  input  wire        s_wvalid,
  output wire        s_wready,
  output wire [1:0]  s_bresp,
  output wire        s_bvalid,
  input  wire        s_bready,
  input  wire [11:0] s_araddr,
  input  wire        s_arvalid,
  output wire        s_arready,
  output wire [31:0] s_rdata,
  output wire [1:0]  s_rresp,
  output wire        s_rvalid,
  input  wire        s_rready,
  // Nonvolatile enable setting
  input  wire        probe_enable_setting,
  // Debug sources
  input  wire [7:0]  clock_grp,
  input  wire [1:0]  tx_grp,
  input  wire [5:0]  timer_grp,
  input  wire [7:0]  card_grp,
  input  wire [7:0]  trx_grp,
  input  wire        rx_collision,
  input  wire        rf_clock,
  // Normal pin functions
  input  wire [3:0]  func_out,
  // Pins
  output reg  [3:0]  pin_out
);

`include "probe_mux_map.vh"

  reg        rst_m_q;
  reg        rst_s_q;
  reg        en_m_q;
  reg        en_s_q;
  reg [7:0]  bank_q;
  reg [3:0]  pin_sel_q [0:3];
  reg [3:0]  pin_act_q;
  reg        ctrl_en_q;
  reg        err_q;
  reg [3:0]  busy_q;
  reg [31:0] rd_data;
  reg        rd_ok;
  reg        wr_ok;
  wire       wr_en;
  wire [11:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire [11:0] rd_addr;
  wire [3:0]  dbg_sig;
  wire [3:0]  dbg_def;
  wire        probe_on;
  wire        cmd_hit;
  wire [2:0]  n_sel;
  integer     i;
  integer     k;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // Enable setting comes from the nonvolatile store: synchronise it
  always @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      en_m_q <= 1'b0;
      en_s_q <= 1'b0;
    end else begin
      en_m_q <= probe_enable_setting;
      en_s_q <= en_m_q;
    end
  end

  probe_axil_slave u_bus (
    .clk        (clk),
    .rst_sync_n (rst_s_q),
    .s_awaddr   (s_awaddr),
    .s_awvalid  (s_awvalid),
    .s_awready  (s_awready),
    .s_wdata    (s_wdata),
    .s_wstrb    (s_wstrb),
    .s_wvalid   (s_wvalid),
    .s_wready   (s_wready),
    .s_bresp    (s_bresp),
    .s_bvalid   (s_bvalid),
    .s_bready   (s_bready),
    .s_araddr   (s_araddr),
    .s_arvalid  (s_arvalid),
    .s_arready  (s_arready),
    .s_rdata    (s_rdata),
    .s_rresp    (s_rresp),
    .s_rvalid   (s_rvalid),
    .s_rready   (s_rready),
    .wr_en      (wr_en),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data),
    .wr_strb    (wr_strb),
    .wr_ok      (wr_ok),
    .rd_addr    (rd_addr),
    .rd_data    (rd_data),
    .rd_ok      (rd_ok)
  );

  // Command word: [31:24] command code, [23:16] pin byte count, [15:0] two pin bytes
  // wdata[7:0] = first pin byte, [15:8] second; third and fourth bytes are not carried,
  // the bank byte comes from the OFS_PIN_CFG write, not from the command word:
  // CMD register takes the code in [31:24] at an OFS_CMD write while not busy.
  assign cmd_hit = wr_en && (wr_addr == `OFS_CMD) && (busy_q == 4'h0);
  assign n_sel   = 3'h4;

  always @* begin
    wr_ok = 1'b0;
    case (wr_addr)
      `OFS_CMD:     wr_ok = 1'b1;
      `OFS_CTRL:    wr_ok = 1'b1;
      `OFS_PIN_CFG: wr_ok = 1'b1;
      default:      wr_ok = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      bank_q    <= `BANK_RESET;
      pin_act_q <= 4'h0;
      ctrl_en_q <= 1'b0;
      err_q     <= 1'b0;
      busy_q    <= 4'h0;
      for (k = 0; k < NUM_PINS; k = k + 1) begin
        pin_sel_q[k] <= `SEL_RESET;
      end
    end else begin
      if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1; // R16
      end
      if (wr_en && (wr_addr == `OFS_CTRL) && wr_strb[0]) begin
        ctrl_en_q <= wr_data[`CTRL_ENABLE_BIT];
        if (wr_data[`STAT_ERR_BIT]) begin
          err_q <= 1'b0;
        end
      end
      if (wr_en && (wr_addr == `OFS_PIN_CFG) && wr_strb[0]) begin
        bank_q <= wr_data[7:0];
      end
      // Command: wdata[31:24] code, [23:16] count, [15:0] first two pin bytes;
      // pin bytes are taken from CMD bytes 0 and 1 only; PIN_CFG byte 0 holds the bank
      if (cmd_hit) begin
        if (wr_data[31:24] == `CMD_PROBE_SETUP && wr_data[23:16] >= 8'h01 &&
            wr_data[23:16] <= 8'h04) begin // R1
          busy_q <= `BUSY_CYCLES; // R16
          for (k = 0; k < MAX_SEL; k = k + 1) begin
            if (k < wr_data[18:16]) begin
              // Pin bytes sit in byte lanes 0 and 1 of OFS_CMD bits [15:0]; later bytes are ignored
              if (k < 2) begin
                if (wr_data[8*k+7 -: 4] < 4'h4) begin
                  pin_sel_q[wr_data[8*k+5 -: 2]] <= wr_data[8*k+3 -: 4]; // R3 R7
                  pin_act_q[wr_data[8*k+5 -: 2]] <= 1'b1; // R4
                end else begin
                  err_q <= 1'b1; // R18
                end
              end
            end
          end
        end else begin
          err_q <= 1'b1;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pin
      probe_bank_select u_sel (
        .bank         (bank_q),
        .sel          (pin_sel_q[g]),
        .clock_grp    (clock_grp),
        .tx_grp       (tx_grp),
        .timer_grp    (timer_grp),
        .card_grp     (card_grp),
        .trx_grp      (trx_grp),
        .rx_collision (rx_collision),
        .rf_clock     (rf_clock),
        .sig          (dbg_sig[g]),
        .defined      (dbg_def[g])
      );
    end
  endgenerate

  assign probe_on = en_s_q && ctrl_en_q; // R2

  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      if (probe_on && pin_act_q[i]) begin
        pin_out[i] = dbg_sig[i] & dbg_def[i]; // R5 R18
      end else begin
        pin_out[i] = func_out[i]; // R17
      end
    end
  end

  always @* begin
    rd_ok   = 1'b1;
    rd_data = 32'h00000000;
    case (rd_addr)
      `OFS_CMD:     rd_data = 32'h00000000;
      `OFS_CTRL:    rd_data = {31'h00000000, ctrl_en_q};
      `OFS_STATUS:  rd_data = {28'h0000000, pin_act_q[3:2], err_q, busy_q != 4'h0};
      `OFS_PIN_CFG: rd_data = {8'h00, pin_sel_q[3], pin_sel_q[2], pin_sel_q[1], pin_sel_q[0], bank_q};
      default:      rd_ok   = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// File: testbench/probe_sources.sv
`timescale 1ns/100ps
`default_nettype none
// Internal debug sources; fresh levels on each shuffle
module probe_sources (
  // Control
  input  wire logic       clk,
  input  wire logic       shuffle,
  // Sources
  output var  logic [7:0] clock_grp,
  output var  logic [1:0] tx_grp,
  output var  logic [5:0] timer_grp,
  output var  logic [7:0] card_grp,
  output var  logic [7:0] trx_grp,
  output var  logic       rx_collision,
  output var  logic       rf_clock,
  output var  logic [3:0] func_out
);
  initial begin
    {clock_grp, tx_grp, timer_grp, card_grp} = 24'h0;
    {trx_grp, rx_collision, rf_clock, func_out} = 14'h0;
  end
  always @(posedge clk) begin
    if (shuffle) begin
      {clock_grp, tx_grp, timer_grp, card_grp} <= 24'($urandom);
      {trx_grp, rx_collision, rf_clock, func_out} <= 14'($urandom);
    end
  end
endmodule
`default_nettype wire

// File: testbench/digital_test_signal_mux_props.sv
`timescale 1ns/100ps
`default_nettype none
module digital_test_signal_mux_props #(
  parameter NUM_PINS = 4,
  parameter MAX_SEL  = 4
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus
  input wire logic [11:0] s_awaddr,
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0]  s_rresp,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  // Pins
  input wire logic        probe_enable_setting,
  input wire logic [3:0]  func_out,
  input wire logic [3:0]  pin_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_nv_off;
    !probe_enable_setting [*3] |-> pin_out == func_out;
  endproperty
  a_nv_off: assert property (p_nv_off) else $error("pin driven while disabled");
  property p_b_hold;
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata) && $stable(s_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_r_lat;
    s_arvalid && s_arready |=> s_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_lat;
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_w_block;
    s_bvalid |-> !s_awready && !s_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken during response");
  property p_ar_block;
    s_rvalid |-> !s_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken during response");
  property p_rd_unmap;
    s_arvalid && s_arready && s_araddr[11:4] != 8'h00 |=> s_rresp == 2'h2 && s_rdata == 32'h0;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not refused");
  property p_wr_unmap;
    s_awvalid && s_awready && s_wvalid && s_wready && s_awaddr[11:4] != 8'h00
      |-> ##[1:2] s_bvalid && s_bresp == 2'h2;
  endproperty
  a_wr_unmap: assert property (p_wr_unmap) else $error("unmapped write not refused");
endmodule
bind digital_test_signal_mux digital_test_signal_mux_props #(.NUM_PINS(NUM_PINS), .MAX_SEL(MAX_SEL)) u_props (
  .clk, .rst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
  .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
  .probe_enable_setting, .func_out, .pin_out);
`default_nettype wire

// File: testbench/digital_test_signal_mux_tb.sv
`timescale 1ns/100ps
`default_nettype none
module digital_test_signal_mux_tb;
  typedef struct {string n; logic [33:0] v;} note_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] s_awaddr = 12'h0, s_araddr = 12'h0;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0]  s_wstrb = 4'hF;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic        probe_enable_setting = 1'b0, shuffle = 1'b0, pin_chk = 1'b0;
  wire logic   s_awready, s_wready, s_bvalid, s_arready, s_rvalid, rx_collision, rf_clock;
  wire logic [1:0]  s_bresp, s_rresp, tx_grp;
  wire logic [31:0] s_rdata;
  wire logic [7:0]  clock_grp, card_grp, trx_grp;
  wire logic [5:0]  timer_grp;
  wire logic [3:0]  func_out, pin_out;
  int          fails = 0, total_checks = 0;
  note_t       bus_q[$], pin_q[$];
  logic [7:0]  bank_m;
  logic [3:0]  sel_m[4], p, q;
  logic        en_m;
  logic [3:0]  act_m;
  logic [7:0]  banks[8] = '{8'h01, 8'h1B, 8'h1D, 8'h30, 8'h58, 8'h70, 8'h73, 8'h02};
  logic [31:0] bad[4] = '{32'h19010031, 32'h18000031, 32'h18050031, 32'h18010041};

  initial forever #2.5 clk = ~clk;

  digital_test_signal_mux uut (.clk, .rst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .probe_enable_setting, .clock_grp, .tx_grp, .timer_grp, .card_grp,
    .trx_grp, .rx_collision, .rf_clock, .func_out, .pin_out);
  probe_sources src (.clk, .shuffle, .clock_grp, .tx_grp, .timer_grp, .card_grp, .trx_grp,
    .rx_collision, .rf_clock, .func_out);

  task automatic chk(input note_t t, input logic [33:0] g);
    total_checks++;
    if (g !== t.v) begin
      fails++;
      $display("BAD %s exp %h got %h", t.n, t.v, g);
    end
  endtask
  always @(posedge clk) begin
    if (s_bvalid && s_bready) chk(bus_q.pop_front(), {s_bresp, 32'h0});
    if (s_rvalid && s_rready) chk(bus_q.pop_front(), {s_rresp, s_rdata});
    if (pin_chk) chk(pin_q.pop_front(), {30'h0, pin_out});
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bus_q.push_back('{"write resp", {r, 32'h0}});
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid && n < 100);
    s_bready <= 1'b0;
    if (n >= 100) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] v);
    int n;
    bus_q.push_back('{"read data", v});
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid && n < 100);
    s_rready <= 1'b0;
    if (n >= 100) begin
      fails++;
      report_and_stop();
    end
  endtask

  function automatic logic sig(input logic [3:0] s);
    if (s == 4'h8) return rf_clock;
    if (s > 4'h8) return 1'b0;
    case (bank_m)
      8'h01: return clock_grp[s];
      8'h1B: return (s < 4'h2) ? tx_grp[s] : 1'b0;
      8'h1D: return (s > 4'h1) ? timer_grp[s - 4'h2] : 1'b0;
      8'h30: return card_grp[s];
      8'h58: return trx_grp[s];
      8'h70: return (s == 4'h7) ? rx_collision : 1'b0;
      default: return 1'b0;
    endcase
  endfunction
  task automatic pins(input string nm);
    logic [3:0] e;
    shuffle <= 1'b1;
    @(posedge clk);
    shuffle <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) e[i] = (en_m && act_m[i]) ? sig(sel_m[i]) : func_out[i];
    pin_q.push_back('{nm, {30'h0, e}});
    pin_chk <= 1'b1;
    @(posedge clk);
    pin_chk <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end

  initial begin
    void'($urandom(89));
    bank_m = 8'h00;
    en_m = 1'b0;
    act_m = 4'h0;
    sel_m = '{4{4'hF}};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(12'h004, 34'h0);
    rd(12'h008, 34'h0);
    rd(12'h010, {2'h2, 32'h0});
    wr(12'h020, 32'h1, 2'h2);
    pins("pins reset");
    probe_enable_setting <= 1'b1;
    wr(12'h004, 32'h1, 2'h0);
    en_m = 1'b1;
    pins("pins unconfigured");
    $display("test reset done");
    foreach (banks[b]) begin
      wr(12'h00C, {24'h0, banks[b]}, 2'h0);
      bank_m = banks[b];
      for (int s = 0; s < 16; s++) begin
        if ((bank_m == 8'h70 && s < 7) || (bank_m == 8'h73 && s < 8)) continue;
        p = 4'($urandom_range(3));
        q = p ^ 4'($urandom_range(3, 1));
        wr(12'h000, {16'h1802, q, 4'h8, p, 4'(s)}, 2'h0);
        sel_m[p] = 4'(s);
        sel_m[q] = 4'h8;
        act_m[p] = 1'b1;
        act_m[q] = 1'b1;
        repeat (8) @(posedge clk);
        pins("pins sweep");
      end
    end
    rd(12'h008, {30'h0, act_m[3:2], 2'h0});
    $display("test sweep done");
    foreach (bad[i]) begin
      wr(12'h000, bad[i], 2'h0);
      repeat (8) @(posedge clk);
      rd(12'h008, {30'h0, act_m[3:2], 2'h2});
      wr(12'h004, 32'h3, 2'h0);
      rd(12'h008, {30'h0, act_m[3:2], 2'h0});
      pins("pins after bad command");
    end
    wr(12'h00C, 32'h1, 2'h0);
    bank_m = 8'h01;
    wr(12'h000, 32'h18013820, 2'h0);
    sel_m[2] = 4'h0;
    act_m[2] = 1'b1;
    repeat (8) @(posedge clk);
    pins("pins single byte");
    $display("test commands done");
    wr(12'h004, 32'h0, 2'h0);
    en_m = 1'b0;
    pins("pins control off");
    wr(12'h004, 32'h1, 2'h0);
    probe_enable_setting <= 1'b0;
    pins("pins setting off");
    $display("test enable done");
    report_and_stop();
  end
endmodule
`default_nettype wire
